// ### iprc_field.sv
// one priority register: masked storage with reset value
`timescale 1ns/1ns
`default_nettype none
module iprc_field
   import iprc_pkg::*;
#(
   parameter logic [15:0] MASK = IPRC_MASK_FULL,
   parameter logic [15:0] RST = IPRC_RST_FULL
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic i_we,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_value
);
   logic [15:0] value;
   logic [15:0] next_value;

   always_comb begin
      next_value = value;
      if (i_we) begin
         next_value = i_wdata & MASK;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         value <= RST;
      end else begin
         value <= next_value;
      end
   end

   assign o_value = value & MASK;

   a_unimpl_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
      (o_value & ~MASK) == 16'h0000) else $error("unimplemented bit set");
   a_write_takes: assert property (@(posedge I_CLK) disable iff (I_RST)
      i_we |=> o_value == ($past(i_wdata) & MASK)) else $error("write lost");
   a_hold_value: assert property (@(posedge I_CLK) disable iff (I_RST)
      !i_we |=> $stable(o_value)) else $error("value changed without write");
endmodule
`default_nettype wire

// ### iprc_pkg.sv
// package: register map, field layout and reset values of the priority control bank
// Operation
// - code seven is the highest priority level a source may hold
// - code one gives the lowest active priority level, one
// - code zero disables the source; it is never reported active
// - unimplemented bits read zero and ignore writes
// - every field resets to binary 100, priority level four
// - implemented field bits are readable and writable at any time
// - register three holds DMA1 at 10-8, ADC1 at 6-4, UART1 transmit at 2-0
// - register four holds pin change at 14-12, I2C1 master 6-4, slave 2-0
// - register five holds capture 8, capture 7, ADC2, external 1
// - register six holds timer 4, compare 4, compare 3, DMA2
// - register seven holds UART2 transmit, receive, external 2, timer 5
package iprc_pkg;
   localparam int IPRC_AW = 4;
   localparam int IPRC_DW = 16;
   localparam int IPRC_NSRC = 18;
   localparam logic [3:0] IPRC_OFS_CTRL3 = 4'h0;
   localparam logic [3:0] IPRC_OFS_CTRL4 = 4'h2;
   localparam logic [3:0] IPRC_OFS_CTRL5 = 4'h4;
   localparam logic [3:0] IPRC_OFS_CTRL6 = 4'h6;
   localparam logic [3:0] IPRC_OFS_CTRL7 = 4'h8;
   localparam logic [2:0] IPRC_FIELD_RST = 3'h4;
   localparam logic [2:0] IPRC_PRIO_OFF = 3'h0;
   localparam logic [15:0] IPRC_MASK3 = 16'h0777;
   localparam logic [15:0] IPRC_MASK4 = 16'h7077;
   localparam logic [15:0] IPRC_MASK_FULL = 16'h7777;
   localparam logic [15:0] IPRC_RST3 = 16'h0444;
   localparam logic [15:0] IPRC_RST4 = 16'h4044;
   localparam logic [15:0] IPRC_RST_FULL = 16'h4444;
   localparam int IPRC_F3 = 12;
   localparam int IPRC_F2 = 8;
   localparam int IPRC_F1 = 4;
   localparam int IPRC_F0 = 0;

   typedef struct packed {
      logic [2:0] level;
      logic active;
   } iprc_prio_t;

   typedef struct packed {
      logic [IPRC_AW-1:0] addr;
      logic [IPRC_DW-1:0] wdata;
      logic wr;
      logic rd;
   } iprc_bus_t;
endpackage

// ### iprc_top.sv
// top: bank of five priority control registers with decoded per-source levels
`timescale 1ns/1ns
`default_nettype none
module iprc_top
   import iprc_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [IPRC_AW-1:0] I_ADDR,
   input wire logic [IPRC_DW-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [IPRC_DW-1:0] O_RDATA,
   output logic [IPRC_NSRC*3-1:0] O_LEVEL,
   output logic [IPRC_NSRC-1:0] O_ACTIVE
);
   iprc_bus_t bus;
   logic [15:0] reg3, reg4, reg5, reg6, reg7;
   logic [4:0] we;
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   logic [IPRC_NSRC*3-1:0] codes;
   iprc_prio_t prio [IPRC_NSRC];

   assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

   // writes to unmapped offsets are dropped silently
   always_comb begin
      we = 5'h00;
      if (bus.wr) begin
         unique case (bus.addr)
            IPRC_OFS_CTRL3: we = 5'h01;
            IPRC_OFS_CTRL4: we = 5'h02;
            IPRC_OFS_CTRL5: we = 5'h04;
            IPRC_OFS_CTRL6: we = 5'h08;
            IPRC_OFS_CTRL7: we = 5'h10;
            default: we = 5'h00;
         endcase
      end
   end

   iprc_field #(.MASK(IPRC_MASK3), .RST(IPRC_RST3)) u_ctrl3 (
      .I_CLK(I_CLK), .I_RST(I_RST), .i_we(we[0]), .i_wdata(bus.wdata), .o_value(reg3));
   iprc_field #(.MASK(IPRC_MASK4), .RST(IPRC_RST4)) u_ctrl4 (
      .I_CLK(I_CLK), .I_RST(I_RST), .i_we(we[1]), .i_wdata(bus.wdata), .o_value(reg4));
   iprc_field #(.MASK(IPRC_MASK_FULL), .RST(IPRC_RST_FULL)) u_ctrl5 (
      .I_CLK(I_CLK), .I_RST(I_RST), .i_we(we[2]), .i_wdata(bus.wdata), .o_value(reg5));
   iprc_field #(.MASK(IPRC_MASK_FULL), .RST(IPRC_RST_FULL)) u_ctrl6 (
      .I_CLK(I_CLK), .I_RST(I_RST), .i_we(we[3]), .i_wdata(bus.wdata), .o_value(reg6));
   iprc_field #(.MASK(IPRC_MASK_FULL), .RST(IPRC_RST_FULL)) u_ctrl7 (
      .I_CLK(I_CLK), .I_RST(I_RST), .i_we(we[4]), .i_wdata(bus.wdata), .o_value(reg7));

   // read data valid only in the cycle after the strobe; unmapped reads zero
   always_comb begin
      next_rdata = 16'h0000;
      if (bus.rd) begin
         unique case (bus.addr)
            IPRC_OFS_CTRL3: next_rdata = reg3;
            IPRC_OFS_CTRL4: next_rdata = reg4;
            IPRC_OFS_CTRL5: next_rdata = reg5;
            IPRC_OFS_CTRL6: next_rdata = reg6;
            IPRC_OFS_CTRL7: next_rdata = reg7;
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign O_RDATA = rdata;

   // source order, index 0 first: dma1, adc1, uart1_tx, pin_change, i2c1_master,
   // i2c1_slave, capture8, capture7, adc2, ext_irq1, timer4, compare4, compare3,
   // dma2, uart2_tx, uart2_rx, ext_irq2, timer5
   assign codes = {
      reg7[IPRC_F0 +: 3], reg7[IPRC_F1 +: 3], reg7[IPRC_F2 +: 3], reg7[IPRC_F3 +: 3],
      reg6[IPRC_F0 +: 3], reg6[IPRC_F1 +: 3], reg6[IPRC_F2 +: 3], reg6[IPRC_F3 +: 3],
      reg5[IPRC_F0 +: 3], reg5[IPRC_F1 +: 3], reg5[IPRC_F2 +: 3], reg5[IPRC_F3 +: 3],
      reg4[IPRC_F0 +: 3], reg4[IPRC_F1 +: 3], reg4[IPRC_F3 +: 3],
      reg3[IPRC_F0 +: 3], reg3[IPRC_F1 +: 3], reg3[IPRC_F2 +: 3]};

   // the code is the level itself, so arbitration can compare levels directly
   genvar g;
   generate
      for (g = 0; g < IPRC_NSRC; g++) begin : g_src
         assign prio[g].level = codes[g*3 +: 3];
         assign prio[g].active = codes[g*3 +: 3] != IPRC_PRIO_OFF;
         assign O_LEVEL[g*3 +: 3] = prio[g].level;
         assign O_ACTIVE[g] = prio[g].active;
      end
   endgenerate

   a_read_data: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_RD && I_ADDR == IPRC_OFS_CTRL5) |=> O_RDATA == $past(reg5))
      else $error("read data wrong");
   a_idle_read_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
      !I_RD |=> O_RDATA == 16'h0000) else $error("read data outside read slot");
   a_zero_disables: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_ACTIVE[0] == (O_LEVEL[2:0] != 3'h0)) else $error("active flag wrong");
   a_write_to_level: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WR && I_ADDR == IPRC_OFS_CTRL7) |=> O_LEVEL[53:51] == $past(I_WDATA[2:0]))
      else $error("timer5 level wrong");
   a_reg4_hole: assert property (@(posedge I_CLK) disable iff (I_RST)
      reg4[11:7] == 5'h00) else $error("register four hole set");
   a_reg3_top: assert property (@(posedge I_CLK) disable iff (I_RST)
      reg3[15:11] == 5'h00) else $error("register three top set");
   a_seven_top: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WR && I_ADDR == IPRC_OFS_CTRL6 && I_WDATA[14:12] == 3'h7)
      |=> O_LEVEL[32:30] == 3'h7 && O_ACTIVE[10]) else $error("level seven lost");
   a_one_low: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WR && I_ADDR == IPRC_OFS_CTRL5 && I_WDATA[2:0] == 3'h1)
      |=> O_LEVEL[29:27] == 3'h1 && O_ACTIVE[9]) else $error("level one lost");
   a_reset_four: assert property (@(posedge I_CLK)
      $fell(I_RST) |-> O_LEVEL[2:0] == 3'h4 && reg6 == IPRC_RST_FULL)
      else $error("reset value wrong");
   // readback of every register, not only the one above
   a_read_ctrl3: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_RD && I_ADDR == IPRC_OFS_CTRL3) |=> O_RDATA == $past(reg3))
      else $error("register three read wrong");
   a_read_ctrl4: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_RD && I_ADDR == IPRC_OFS_CTRL4) |=> O_RDATA == $past(reg4))
      else $error("register four read wrong");
   a_read_ctrl6: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_RD && I_ADDR == IPRC_OFS_CTRL6) |=> O_RDATA == $past(reg6))
      else $error("register six read wrong");
   a_read_ctrl7: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_RD && I_ADDR == IPRC_OFS_CTRL7) |=> O_RDATA == $past(reg7))
      else $error("register seven read wrong");
   // the gaps between fields of the full registers must never hold ones
   a_reg5_gaps: assert property (@(posedge I_CLK) disable iff (I_RST)
      (reg5 & ~IPRC_MASK_FULL) == 16'h0000) else $error("register five gap set");
   a_reg6_gaps: assert property (@(posedge I_CLK) disable iff (I_RST)
      (reg6 & ~IPRC_MASK_FULL) == 16'h0000) else $error("register six gap set");
   a_reg7_gaps: assert property (@(posedge I_CLK) disable iff (I_RST)
      (reg7 & ~IPRC_MASK_FULL) == 16'h0000) else $error("register seven gap set");
   // the first source of registers three, four, five and seven, and the last (dma2) of six, follows its field after a write
   a_dma1_level: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WR && I_ADDR == IPRC_OFS_CTRL3) |=> O_LEVEL[2:0] == $past(I_WDATA[10:8]))
      else $error("dma1 level wrong");
   a_pin_level: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WR && I_ADDR == IPRC_OFS_CTRL4) |=> O_LEVEL[11:9] == $past(I_WDATA[14:12]))
      else $error("pin change level wrong");
   a_cap8_level: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WR && I_ADDR == IPRC_OFS_CTRL5) |=> O_LEVEL[20:18] == $past(I_WDATA[14:12]))
      else $error("capture8 level wrong");
   a_dma2_level: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WR && I_ADDR == IPRC_OFS_CTRL6) |=> O_LEVEL[41:39] == $past(I_WDATA[2:0]))
      else $error("dma2 level wrong");
   a_u2tx_level: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WR && I_ADDR == IPRC_OFS_CTRL7) |=> O_LEVEL[44:42] == $past(I_WDATA[14:12]))
      else $error("uart2 transmit level wrong");
   a_off_inactive: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_ACTIVE[17] == (O_LEVEL[53:51] != IPRC_PRIO_OFF)) else $error("timer5 active wrong");
endmodule
`default_nettype wire

// ### test_irq_priority_regs_3_to_7.sv
// testbench: register access, reset values and level decoding of the priority bank
`timescale 1ns/1ns
`default_nettype none
module test_irq_priority_regs_3_to_7;
   import iprc_pkg::*;
   // register index and field position of every source, in output order
   localparam int SREG[18] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4};
   localparam int SPOS[18] = '{8, 4, 0, 12, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0};
   localparam logic [15:0] MSK[5] = '{IPRC_MASK3, IPRC_MASK4, IPRC_MASK_FULL, IPRC_MASK_FULL,
                                      IPRC_MASK_FULL};
   localparam logic [15:0] RSTV[5] = '{IPRC_RST3, IPRC_RST4, IPRC_RST_FULL, IPRC_RST_FULL,
                                       IPRC_RST_FULL};
   localparam logic [15:0] PAT[5] = '{16'hFDB9, 16'hF9DB, 16'hBFD9, 16'h9BDF, 16'hDF9B};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic [IPRC_NSRC*3-1:0] level;
   logic [IPRC_NSRC-1:0] active;
   logic [15:0] cur[5];
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   iprc_top DUT (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(we),
      .I_RD(re), .O_RDATA(rdata), .O_LEVEL(level), .O_ACTIVE(active));
   always #50 clk = ~clk;
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      // model: only even offsets up to 0x8 hold storage
      if (a[0] == 1'b0 && a <= 4'h8) cur[a[3:1]] = d & MSK[a[3:1]];
   endtask
   task automatic bus_rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 chk("read data", e, rdata);
   endtask
   task automatic check_all();
      for (int r = 0; r < 5; r++) bus_rd(4'(2 * r), cur[r]);
      for (int g = 0; g < 18; g++) begin
         chk("level", 16'(cur[SREG[g]][SPOS[g] +: 3]), 16'(level[3 * g +: 3]));
         chk("active", 16'(cur[SREG[g]][SPOS[g] +: 3] != 3'h0), 16'(active[g]));
      end
   endtask
   task automatic reset_dut();
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int r = 0; r < 5; r++) cur[r] = RSTV[r];
   endtask
   task automatic t_codes();
      // every code in every field; the top bit of each nibble written as one
      for (int c = 0; c < 8; c++) begin
         for (int r = 0; r < 5; r++) bus_wr(4'(2 * r), {4{1'b1, 3'(c)}});
         check_all();
      end
   endtask
   task automatic t_layout();
      for (int r = 0; r < 5; r++) bus_wr(4'(2 * r), PAT[r]);
      check_all();
      bus_wr(4'hA, 16'hFFFF);
      bus_wr(4'h3, 16'h0000);
      bus_rd(4'hA, 16'h0000);
      bus_rd(4'hF, 16'h0000);
      check_all();
   endtask
   task automatic t_back_to_back();
      // read issued in the cycle right after the write must see the new value
      @(posedge clk);
      addr <= 4'h6;
      wdata <= 16'h1234;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      re <= 1'b1;
      cur[3] = 16'h1234;
      @(posedge clk);
      re <= 1'b0;
      #1 chk("read after write", 16'h1234, rdata);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      reset_dut();
      check_all();
      t_codes();
      t_layout();
      t_back_to_back();
      reset_dut();
      check_all();
      give_verdict();
   end
endmodule
`default_nettype wire
